// file: lasf_consts.vh
// constants for the luma adaptive sharpness filter
// Function
// - three filter modes: fixed-gain sharpness plus two edge-adaptive modes
// - sharpness mode when sharpness enable is 1 and adaptive enable is 0
// - sharpness mode applies signed gains -8..+7 from base gain register
// - adaptive filtering only when both enables are 1
// - adaptive path compares luma derivative with small, medium, large thresholds
// - adaptive path delays luma eight samples so decisions align with edges
// - mode select 0: low-pass adaptive only, band-pass gain fixed
// - mode select 1: cascade both filters, both nibble gains apply
// - derivative above small but below medium selects low-band gain register
// - derivative above medium but below large selects mid-band gain register
// - derivative above large selects high-band gain register
// - low nibble of adaptive gains ignored unless cascaded mode selected
// - below small threshold uses base gain; exactly one gain source active
// - gain registers preloadable, take effect automatically when condition met
// - medium threshold has precedence over small threshold
// - large threshold has precedence over small and medium thresholds
// - thresholds accept any 8-bit value 0..255
// - gain register bits 3-0 band-pass gain, bits 7-4 low-pass gain
// - sharpness mode cascades band-pass and low-pass filters
`ifndef LASF_CONSTS_VH
`define LASF_CONSTS_VH

`define LASF_ADDR_BASE_GAIN     6'h10
`define LASF_ADDR_GAIN_LOW      6'h22
`define LASF_ADDR_GAIN_MID      6'h23
`define LASF_ADDR_GAIN_HIGH     6'h24
`define LASF_ADDR_THR_SMALL     6'h25
`define LASF_ADDR_THR_MEDIUM    6'h26
`define LASF_ADDR_THR_LARGE     6'h27
`define LASF_ADDR_STATUS        6'h28

`define LASF_RST_GAIN           8'h00
`define LASF_RST_THR_SMALL      8'h10
`define LASF_RST_THR_MEDIUM     8'h40
`define LASF_RST_THR_LARGE      8'h80

`define LASF_GAIN_BP_LSB        0
`define LASF_GAIN_BP_MSB        3
`define LASF_GAIN_LP_LSB        4
`define LASF_GAIN_LP_MSB        7
`define LASF_FIXED_BP_GAIN      4'h0

`define LASF_LUMA_W             10
`define LASF_FIFO_DEPTH         16
`define LASF_FIFO_AW            4
`define LASF_WIN_TAPS           11
`define LASF_CENTER_TAP         8
`define LASF_EDGE_SPAN          8
`define LASF_FILL_FULL          4'hb
`define LASF_GAIN_SHIFT         4

`define LASF_SRC_BASE           2'h0
`define LASF_SRC_LOW            2'h1
`define LASF_SRC_MID            2'h2
`define LASF_SRC_HIGH           2'h3

`define LASF_MODE_BYPASS        2'h0
`define LASF_MODE_SHARP         2'h1
`define LASF_MODE_ADAPT_LP      2'h2
`define LASF_MODE_ADAPT_CASC    2'h3

`endif

// file: lasf_filter.v
// luma sharpness / edge-adaptive filter with input fifo
`timescale 1ns/100ps
`include "lasf_consts.vh"

module lasf_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_sys,   // system clock
    input  wire             rst_n,     // async reset, active low
    input  wire [WIDTH-1:0] inData,    // write data
    input  wire             inValid,   // write request
    output wire             inReady,   // not full
    output wire [WIDTH-1:0] outData,   // head word
    output wire             outValid,  // not empty
    input  wire             outReady   // drain request
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wrPtr_r;
    reg  [AW-1:0]    rdPtr_r;
    reg  [AW:0]      count_r;
    wire             doWr;
    wire             doRd;

    assign inReady  = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_r];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always @(posedge clk_sys) begin
        if (doWr) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (doWr && !doRd) begin
                count_r <= count_r + 1'b1;
            end else if (doRd && !doWr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // lasf_fifo

module lasf_filter (
    input  wire       clk_sys,          // 10 MHz system clock
    input  wire       rst_n,            // async reset, active low
    input  wire [9:0] lumaIn,           // incoming luma sample
    input  wire       lumaInValid,      // sample offered
    output wire       lumaInReady,      // fifo can take sample
    output reg  [9:0] lumaOut_r,        // filtered luma
    output reg        lumaOutValid_r,   // filtered sample held
    input  wire       lumaOutReady,     // downstream takes sample
    output reg  [1:0] gainSrc_r,        // gain source used for lumaOut_r
    output reg  [1:0] filterMode_r,     // mode used for lumaOut_r
    input  wire       sharpnessEnable,  // sharpness enable bit
    input  wire       adaptiveEnable,   // adaptive control enable bit
    input  wire       adaptiveModeSel,  // 0 low-pass only, 1 cascade
    input  wire [5:0] regAddr,          // register sub-address
    input  wire [7:0] regWrData,        // register write data
    input  wire       regWrEn,          // register write strobe
    output reg  [7:0] regRdData_r       // register read data
);
    reg  [7:0]  baseGain_r;
    reg  [7:0]  gainLow_r;
    reg  [7:0]  gainMid_r;
    reg  [7:0]  gainHigh_r;
    reg  [7:0]  thrSmall_r;
    reg  [7:0]  thrMedium_r;
    reg  [7:0]  thrLarge_r;
    reg  [9:0]  tap_r [0:`LASF_WIN_TAPS-1];
    reg  [1:0]  edgeCode_r [0:`LASF_EDGE_SPAN-1];
    reg  [3:0]  fill_r;
    wire [9:0]  fifoData;
    wire        fifoValid;
    wire        advance;
    wire        primed;
    wire [10:0] diffRaw;
    wire [9:0]  diffMag;
    wire [7:0]  deriv;
    reg  [1:0]  newCode;
    reg  [1:0]  maxCode;
    reg  [1:0]  mode;
    reg  [1:0]  src;
    reg  [7:0]  selGain;
    reg  [3:0]  gainBp;
    reg  [3:0]  gainLp;
    wire [11:0] lpSum;
    wire signed [11:0] bpTerm;
    wire signed [11:0] lpTerm;
    wire signed [15:0] gainBpWide;
    wire signed [15:0] gainLpWide;
    wire signed [15:0] bpWide;
    wire signed [15:0] lpWide;
    wire signed [15:0] prodBp;
    wire signed [15:0] prodLp;
    wire signed [16:0] prodSum;
    wire signed [16:0] prodShift;
    wire signed [17:0] acc;
    reg  [9:0]  result;
    integer     i;
    integer     e;

    lasf_fifo #(
        .WIDTH (`LASF_LUMA_W),
        .DEPTH (`LASF_FIFO_DEPTH),
        .AW    (`LASF_FIFO_AW)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inData   (lumaIn),
        .inValid  (lumaInValid),
        .inReady  (lumaInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (advance)
    );

    // a stalled output register stalls the window and lets the fifo fill
    assign advance = fifoValid && (!lumaOutValid_r || lumaOutReady);
    assign primed  = (fill_r == `LASF_FILL_FULL);

    // edge size of the sample entering the window
    assign diffRaw = {1'b0, fifoData} - {1'b0, tap_r[0]};
    assign diffMag = diffRaw[10] ? (10'h000 - diffRaw[9:0]) : diffRaw[9:0];
    assign deriv   = diffMag[9:2];

    always @* begin
        // strict compares; large checked first, then medium, then small
        if (deriv > thrLarge_r) begin
            newCode = `LASF_SRC_HIGH;
        end else if (deriv > thrMedium_r) begin
            newCode = `LASF_SRC_MID;
        end else if (deriv > thrSmall_r) begin
            newCode = `LASF_SRC_LOW;
        end else begin
            newCode = `LASF_SRC_BASE;
        end
    end

    // strongest edge seen across the eight sample intervals ahead of the centre
    always @* begin
        maxCode = `LASF_SRC_BASE;
        for (e = 0; e < `LASF_EDGE_SPAN; e = e + 1) begin
            if (edgeCode_r[e] > maxCode) begin
                maxCode = edgeCode_r[e];
            end
        end
    end

    always @* begin
        if (!sharpnessEnable) begin
            mode = `LASF_MODE_BYPASS;
        end else if (!adaptiveEnable) begin
            mode = `LASF_MODE_SHARP;
        end else if (!adaptiveModeSel) begin
            mode = `LASF_MODE_ADAPT_LP;
        end else begin
            mode = `LASF_MODE_ADAPT_CASC;
        end
    end

    always @* begin
        src = `LASF_SRC_BASE;
        if (mode == `LASF_MODE_ADAPT_LP || mode == `LASF_MODE_ADAPT_CASC) begin
            src = maxCode;
        end
        case (src)
            `LASF_SRC_LOW:  selGain = gainLow_r;
            `LASF_SRC_MID:  selGain = gainMid_r;
            `LASF_SRC_HIGH: selGain = gainHigh_r;
            default:        selGain = baseGain_r;
        endcase
        gainLp = selGain[`LASF_GAIN_LP_MSB:`LASF_GAIN_LP_LSB];
        gainBp = selGain[`LASF_GAIN_BP_MSB:`LASF_GAIN_BP_LSB];
        case (mode)
            `LASF_MODE_BYPASS: begin
                gainLp = 4'h0;
                gainBp = 4'h0;
            end
            `LASF_MODE_ADAPT_LP: begin
                gainBp = `LASF_FIXED_BP_GAIN;
            end
            `LASF_MODE_SHARP: begin
                gainBp = selGain[`LASF_GAIN_BP_MSB:`LASF_GAIN_BP_LSB];
            end
            default: begin
                gainBp = selGain[`LASF_GAIN_BP_MSB:`LASF_GAIN_BP_LSB];
            end
        endcase
    end

    // band-pass and low-pass detail around the centre tap, summed as a cascade
    assign bpTerm  = $signed({1'b0, tap_r[8], 1'b0}) - $signed({2'b00, tap_r[6]})
                     - $signed({2'b00, tap_r[10]});
    assign lpSum   = {2'b00, tap_r[7]} + {1'b0, tap_r[8], 1'b0} + {2'b00, tap_r[9]};
    assign lpTerm  = $signed({2'b00, lpSum[11:2]}) - $signed({2'b00, tap_r[8]});
    // operands widened to the product width so no bit is cut or padded silently
    assign gainBpWide = {{12{gainBp[3]}}, gainBp};
    assign gainLpWide = {{12{gainLp[3]}}, gainLp};
    assign bpWide     = {{4{bpTerm[11]}}, bpTerm};
    assign lpWide     = {{4{lpTerm[11]}}, lpTerm};
    assign prodBp     = gainBpWide * bpWide;
    assign prodLp     = gainLpWide * lpWide;
    assign prodSum    = {prodBp[15], prodBp} + {prodLp[15], prodLp};
    assign prodShift  = prodSum >>> `LASF_GAIN_SHIFT;
    assign acc        = $signed({8'h00, tap_r[`LASF_CENTER_TAP]}) + $signed({prodShift[16], prodShift});

    always @* begin
        if (acc < 18'sd0) begin
            result = 10'h000;
        end else if (acc > 18'sd1023) begin
            result = 10'h3ff;
        end else begin
            result = acc[9:0];
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `LASF_WIN_TAPS; i = i + 1) begin
                tap_r[i] <= 10'h000;
            end
            for (i = 0; i < `LASF_EDGE_SPAN; i = i + 1) begin
                edgeCode_r[i] <= 2'h0;
            end
            fill_r         <= 4'h0;
            lumaOut_r      <= 10'h000;
            lumaOutValid_r <= 1'b0;
            gainSrc_r      <= 2'h0;
            filterMode_r   <= 2'h0;
        end else begin
            if (advance) begin
                tap_r[0]      <= fifoData;
                edgeCode_r[0] <= newCode;
                for (i = 1; i < `LASF_WIN_TAPS; i = i + 1) begin
                    tap_r[i] <= tap_r[i-1];
                end
                for (i = 1; i < `LASF_EDGE_SPAN; i = i + 1) begin
                    edgeCode_r[i] <= edgeCode_r[i-1];
                end
                if (!primed) begin
                    fill_r <= fill_r + 4'h1;
                end
            end
            if (advance && primed) begin
                lumaOut_r      <= result;
                lumaOutValid_r <= 1'b1;
                gainSrc_r      <= src;
                filterMode_r   <= mode;
            end else if (lumaOutReady) begin
                lumaOutValid_r <= 1'b0;
            end
        end
    end

    // register writes; all values 0..255 are accepted as written
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            baseGain_r  <= `LASF_RST_GAIN;
            gainLow_r   <= `LASF_RST_GAIN;
            gainMid_r   <= `LASF_RST_GAIN;
            gainHigh_r  <= `LASF_RST_GAIN;
            thrSmall_r  <= `LASF_RST_THR_SMALL;
            thrMedium_r <= `LASF_RST_THR_MEDIUM;
            thrLarge_r  <= `LASF_RST_THR_LARGE;
        end else if (regWrEn) begin
            case (regAddr)
                `LASF_ADDR_BASE_GAIN: baseGain_r  <= regWrData;
                `LASF_ADDR_GAIN_LOW:  gainLow_r   <= regWrData;
                `LASF_ADDR_GAIN_MID:  gainMid_r   <= regWrData;
                `LASF_ADDR_GAIN_HIGH: gainHigh_r  <= regWrData;
                `LASF_ADDR_THR_SMALL: thrSmall_r  <= regWrData;
                `LASF_ADDR_THR_MEDIUM: thrMedium_r <= regWrData;
                `LASF_ADDR_THR_LARGE: thrLarge_r  <= regWrData;
                default: ;
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_r <= 8'h00;
        end else begin
            case (regAddr)
                `LASF_ADDR_BASE_GAIN:  regRdData_r <= baseGain_r;
                `LASF_ADDR_GAIN_LOW:   regRdData_r <= gainLow_r;
                `LASF_ADDR_GAIN_MID:   regRdData_r <= gainMid_r;
                `LASF_ADDR_GAIN_HIGH:  regRdData_r <= gainHigh_r;
                `LASF_ADDR_THR_SMALL:  regRdData_r <= thrSmall_r;
                `LASF_ADDR_THR_MEDIUM: regRdData_r <= thrMedium_r;
                `LASF_ADDR_THR_LARGE:  regRdData_r <= thrLarge_r;
                `LASF_ADDR_STATUS:     regRdData_r <= {4'h0, filterMode_r, gainSrc_r};
                default:               regRdData_r <= 8'h00;
            endcase
        end
    end
endmodule // lasf_filter

// file: lasf_filter_checker.sv
// port assertions for the luma sharpness filter
`timescale 1ns/100ps
module lasf_filter_checker (
    input wire       clk_sys,          // clock
    input wire       rst_n,            // reset, active low
    input wire [9:0] lumaOut_r,        // filtered luma
    input wire       lumaOutValid_r,   // output valid
    input wire       lumaOutReady,     // output taken
    input wire [1:0] gainSrc_r,        // gain source
    input wire [1:0] filterMode_r,     // mode used
    input wire       sharpnessEnable,  // sharpness enable
    input wire       adaptiveEnable,   // adaptive enable
    input wire       adaptiveModeSel,  // adaptive mode select
    input wire [5:0] regAddr,          // register address
    input wire [7:0] regWrData,        // write data
    input wire       regWrEn,          // write strobe
    input wire [7:0] regRdData_r       // read data
);
    logic outHeld_r;
    wire  newOut = lumaOutValid_r && !outHeld_r;
    // an output still waiting from last cycle is not a new one
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            outHeld_r <= 1'b0;
        else
            outHeld_r <= lumaOutValid_r && !lumaOutReady;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    bypass_mode_a: assert property (newOut && $past(sharpnessEnable) == 1'b0 |-> filterMode_r == 2'h0)
        else $error("bypass output not in mode 0");
    sharp_mode_a: assert property (newOut && $past(sharpnessEnable) && !$past(adaptiveEnable) |-> filterMode_r == 2'h1)
        else $error("sharpness output not in mode 1");
    adapt_mode_a: assert property (newOut && $past(sharpnessEnable) && $past(adaptiveEnable)
        |-> filterMode_r == {1'b1, $past(adaptiveModeSel)}) else $error("adaptive output in wrong mode");
    sharp_source_a: assert property (newOut && filterMode_r == 2'h1 |-> gainSrc_r == 2'h0)
        else $error("sharpness mode used an adaptive gain");
    output_hold_a: assert property (lumaOutValid_r && !lumaOutReady |=> lumaOutValid_r && $stable(lumaOut_r)
        && $stable(gainSrc_r) && $stable(filterMode_r)) else $error("output changed before taken");
    valid_drop_a: assert property ($fell(lumaOutValid_r) |-> $past(lumaOutReady))
        else $error("output dropped without being taken");
    unmapped_read_a: assert property ($past(regAddr) != 6'h10 && ($past(regAddr) < 6'h22 || $past(regAddr) > 6'h28)
        |-> regRdData_r == 8'h00) else $error("unmapped read not zero");
    write_read_a: assert property (regWrEn && regAddr >= 6'h22 && regAddr <= 6'h27 ##1 !regWrEn && $stable(regAddr)
        |=> regRdData_r == $past(regWrData, 2)) else $error("register readback differs from write");
    status_read_a: assert property ($past(regAddr) == 6'h28
        |-> regRdData_r == {4'h0, $past(filterMode_r), $past(gainSrc_r)}) else $error("status read wrong");
endmodule // lasf_filter_checker
bind lasf_filter lasf_filter_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .lumaOut_r(lumaOut_r),
    .lumaOutValid_r(lumaOutValid_r), .lumaOutReady(lumaOutReady), .gainSrc_r(gainSrc_r), .filterMode_r(filterMode_r),
    .sharpnessEnable(sharpnessEnable), .adaptiveEnable(adaptiveEnable), .adaptiveModeSel(adaptiveModeSel),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData_r(regRdData_r));

// file: lasf_pixel_source.sv
// upstream pixel source offering queued luma samples with random pauses
`timescale 1ns/100ps
module lasf_pixel_source (
    input  logic       clk_sys,      // system clock
    input  logic       rst_n,        // reset, active low
    input  logic       stall,        // hold back the next sample
    input  logic       lumaInReady,  // filter takes sample
    output logic [9:0] lumaIn,       // offered sample
    output logic       lumaInValid,  // sample offered
    output logic       pending       // samples still queued
);
    logic [9:0] q[$];
    task automatic push(input logic [9:0] v);
        q.push_back(v);
    endtask
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lumaInValid <= 1'b0;
            lumaIn <= 10'h000;
            pending <= 1'b0;
        end else begin
            if (!lumaInValid || lumaInReady) begin
                if (lumaInValid)
                    void'(q.pop_front());
                if (q.size() != 0 && !stall) begin
                    lumaInValid <= 1'b1;
                    lumaIn <= q[0];
                end else begin
                    lumaInValid <= 1'b0;
                    lumaIn <= ~lumaIn; // idle line inverts every bit of the last sample each cycle
                end
            end
            pending <= q.size() != 0;
        end
    end
endmodule // lasf_pixel_source

// file: tb_luma_adaptive_sharpness_filter.sv
// self-checking bench for the luma adaptive sharpness filter
`timescale 1ns/100ps
module tb_luma_adaptive_sharpness_filter;
    logic        clk_sys, rst_n, lumaInValid, lumaInReady, lumaOutValid_r, lumaOutReady, regWrEn;
    logic        sharpnessEnable, adaptiveEnable, adaptiveModeSel, stall, holdOut, pending;
    logic [9:0]  lumaIn, lumaOut_r;
    logic [1:0]  gainSrc_r, filterMode_r;
    logic [5:0]  regAddr;
    logic [7:0]  regWrData, regRdData_r;
    logic [31:0] ph[7] = '{32'h0010_4080, 32'h0510_4080, 32'h0610_4080, 32'h0710_4080, 32'h07c0_2060,
                           32'h0600_ffff, 32'h0300_ffff};
    logic [5:0]  adr[8] = '{6'h10, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h3f};
    int          fails, comparisons, rg[64], smp[$], cds[$], outIdx, prev, i, j, k, p, s, g, b, f, y, md;

    lasf_filter dut (.clk_sys(clk_sys), .rst_n(rst_n), .lumaIn(lumaIn), .lumaInValid(lumaInValid),
        .lumaInReady(lumaInReady), .lumaOut_r(lumaOut_r), .lumaOutValid_r(lumaOutValid_r),
        .lumaOutReady(lumaOutReady), .gainSrc_r(gainSrc_r), .filterMode_r(filterMode_r),
        .sharpnessEnable(sharpnessEnable), .adaptiveEnable(adaptiveEnable), .adaptiveModeSel(adaptiveModeSel),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData_r(regRdData_r));
    lasf_pixel_source src (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .lumaInReady(lumaInReady),
        .lumaIn(lumaIn), .lumaInValid(lumaInValid), .pending(pending));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        if (a == 6'h10 || (a >= 6'h22 && a <= 6'h27))
            rg[a] = d;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        repeat (2) @(posedge clk_sys);
        #1 check(32'(regRdData_r), rg[a]);
    endtask
    task automatic feed(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            prev = (prev + ($urandom % 3 == 0 ? $urandom : $urandom % 64)) % 1024;
            smp.push_back(prev);
            // edge code fixed with the thresholds in force when the sample enters the window
            cds.push_back(smp.size() < 2 ? 0 : cd(smp.size() - 1));
            src.push(prev[9:0]);
        end
    endtask
    // idle means nothing queued, nothing held and room in the fifo for 4 cycles running
    task automatic settle;
        k = 0;
        for (i = 0; i < 2000 && k < 4; i++) begin
            @(posedge clk_sys);
            k = (!pending && !lumaOutValid_r && lumaInReady) ? k + 1 : 0;
        end
        if (k < 4) begin
            fails++;
            close_out;
        end
    endtask
    function automatic int cd(int n);
        int d;
        d = (smp[n] > smp[n-1] ? smp[n] - smp[n-1] : smp[n-1] - smp[n]) >> 2;
        return d > rg[8'h27] ? 3 : d > rg[8'h26] ? 2 : d > rg[8'h25] ? 1 : 0;
    endfunction
    function automatic int sg(int v);
        return v >= 8 ? v - 16 : v;
    endfunction

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        close_out;
    end
    always @(posedge clk_sys) begin
        lumaOutReady <= !holdOut && ($urandom % 4 != 0);
        stall <= $urandom % 5 == 0;
        if (rst_n && lumaOutValid_r && lumaOutReady) begin
            b = outIdx + 10;
            s = 0;
            for (j = b - 7; j <= b; j++)
                s = cds[j] > s ? cds[j] : s;
            md = !sharpnessEnable ? 0 : !adaptiveEnable ? 1 : 2 + adaptiveModeSel;
            s = md < 2 ? 0 : s;
            g = s == 0 ? rg[8'h10] : rg[8'h21 + s];
            f = md == 0 ? 0 : (md == 2 ? 0 : sg(g & 15)) * (2 * smp[b-8] - smp[b-6] - smp[b-10])
                + sg(g >> 4) * ((smp[b-7] + 2 * smp[b-8] + smp[b-9]) / 4 - smp[b-8]);
            y = smp[b-8] + (f >>> 4);
            y = y < 0 ? 0 : y > 1023 ? 1023 : y;
            check(32'(lumaOut_r), y);
            check(32'(filterMode_r), md);
            if (md > 0)
                check(32'(gainSrc_r), s);
            outIdx++;
        end
    end
    initial begin
        void'($urandom(32'haa9e));
        {rst_n, regWrEn, sharpnessEnable, adaptiveEnable, adaptiveModeSel, regAddr, regWrData} = '0;
        {holdOut, stall, lumaOutReady} = 3'h4;
        rg[8'h25] = 8'h10;
        rg[8'h26] = 8'h40;
        rg[8'h27] = 8'h80;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (p = 0; p < 8; p++)
            rd(adr[p]);
        for (p = 0; p < 6; p++) begin
            wr(6'(37 + p % 3), p < 3 ? 8'h00 : 8'hff);
            rd(6'(37 + p % 3));
        end
        wr(6'h28, 8'h33);
        wr(6'h3f, 8'h5a);
        rd(6'h3f);
        for (p = 0; p < 7; p++) begin
            wr(6'h10, 8'($urandom));
            for (j = 0; j < 3; j++)
                wr(6'(34 + j), 8'($urandom));
            for (j = 0; j < 3; j++)
                wr(6'(37 + j), ph[p][23 - 8 * j -: 8]);
            @(posedge clk_sys);
            {sharpnessEnable, adaptiveEnable, adaptiveModeSel} <= ph[p][26:24];
            regAddr <= 6'h28;
            if (p == 0) begin
                feed(40);
                for (i = 0; i < 300 && lumaInReady; i++)
                    @(posedge clk_sys);
                repeat (4) @(posedge clk_sys);
                check(32'(lumaInReady), 0);
                check(32'(40 - src.q.size()), 28);
                holdOut <= 1'b0;
            end else
                feed(60);
            settle;
        end
        close_out;
    end
endmodule // tb_luma_adaptive_sharpness_filter
